// file: dv/lhp_host.sv
`timescale 1ns/1ps
module lhp_host (
  // Clock and device pins
  input  wire logic [7:0] host_data_out,
  input  wire logic [7:0] host_data_oe_n,
  input  wire logic       clk_sys,
  input  wire logic       nibble_mode,
  output logic            register_select = 1'b1,
  output logic            read_not_write = 1'b1,
  output logic            strobe = 1'b0,
  output logic [7:0]      host_data_in
);
  logic       hdrv = 1'b0;
  logic [7:0] drv = 8'h00;
  // Undriven lines float up to their pull-ups, so stale data never shows.
  wire  [7:0] hm = hdrv ? (nibble_mode ? 8'hf0 : 8'hff) : 8'h00;
  assign host_data_in = ~host_data_oe_n & host_data_out |
                        host_data_oe_n & (hm & drv | ~hm);
  task put(input logic [7:0] d);
    @(posedge clk_sys);
    hdrv <= 1'b1;
    drv <= d;
  endtask
  task xfer(input logic rs, rw, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    register_select <= rs;
    read_not_write <= rw;
    hdrv <= !rw;
    drv <= d;
    @(posedge clk_sys);
    strobe <= 1'b1;
    repeat (6) @(posedge clk_sys);
    q = host_data_in;
    strobe <= 1'b0;
    repeat (6) @(posedge clk_sys);
    hdrv <= 1'b0;
  endtask
endmodule

// file: dv/lhp_port_chk.sv
`timescale 1ns/1ps
module lhp_chk (
  // Pins and state at the block edge
  input wire logic       clk_sys, reset_n, register_select, nibble_mode,
  input wire logic       power_down_in, icon_mode, instr_valid, data_valid,
  input wire logic       gen_enable, power_down, sync_rst_done,
  input wire logic [5:0] vcode_a,
  input wire logic [1:0] mux_rate,
  input wire logic [2:0] bias_levels,
  input wire logic [7:0] host_data_oe_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_instr_route: assert property (
    instr_valid |-> !$past(register_select, 3)) else $error("instr route");
  a_data_route: assert property (
    data_valid |-> $past(register_select, 3)) else $error("data route");
  a_write_release: assert property (
    instr_valid || data_valid |-> &host_data_oe_n) else $error("bus driven");
  a_nibble_lines: assert property (
    nibble_mode && !(&host_data_oe_n) |-> host_data_oe_n == 8'h0f)
    else $error("nibble lines");
  a_bias_four: assert property (
    (mux_rate == 2'h2) [*4] |-> bias_levels == 3'h4) else $error("bias");
  a_gen_off: assert property (
    (!icon_mode && vcode_a == 6'h00) [*4] |-> !gen_enable) else $error("gen");
  a_pd_level: assert property (
    power_down_in [*4] |-> power_down && !gen_enable) else $error("pd");
  a_sync_done: assert property (
    $rose(reset_n) |-> ##[2:4] sync_rst_done) else $error("sync");
  c_instr: cover property (instr_valid);
  c_data: cover property (data_valid);
  c_nibble: cover property (host_data_oe_n == 8'h0f);
endmodule
bind lhp_port lhp_chk chk (.*);

// file: dv/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin error_cnt++;\
 $display("CHECK FAILED %s %h %h", n, e, a); end end
module tb;
  logic       clk_sys = 1'b0, reset_n = 1'b0, nibble_mode = 1'b0;
  logic       serial_sel = 1'b0, power_down_in = 1'b0, icon_mode = 1'b0;
  logic       direct_supply_bit = 1'b0, core_busy = 1'b0;
  logic [5:0] vcode_a = 6'h00, vcode_b = 6'h00;
  logic [1:0] mux_rate = 2'h0;
  logic [6:0] addr_counter = 7'h5a;
  logic [7:0] read_data = 8'hc3, q, last_i, last_d;
  int         error_cnt = 0, check_count = 0, n_i = 0, n_ack = 0;
  wire        register_select, read_not_write, strobe, instr_valid, data_valid;
  wire        data_read_ack, gen_enable, direct_connect, power_down;
  wire        serial_addr_bit, sync_rst_done;
  wire  [7:0] host_data_in, host_data_out, host_data_oe_n, instr_byte, data_byte;
  wire  [5:0] gen_code;
  wire  [2:0] bias_levels;
  always #2 clk_sys = ~clk_sys;
  lhp_port dut (.*);
  lhp_host host (.*);
  always @(posedge clk_sys) begin
    if (instr_valid) last_i <= instr_byte;
    if (instr_valid) n_i <= n_i + 1;
    if (data_valid) last_d <= data_byte;
    if (data_read_ack) n_ack <= n_ack + 1;
  end
  task wt(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task summarize;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #60000;
    error_cnt++;
    summarize();
  end
  initial begin
    wt(5);
    `CHK("oe", 8'hff, host_data_oe_n)
    `CHK("bias", 3'h5, bias_levels)
    @(posedge clk_sys) reset_n <= 1'b1;
    wt(12);
    `CHK("sync", 1'b1, sync_rst_done)
    host.xfer(1'b0, 1'b0, 8'ha5, q);
    `CHK("instr", 8'ha5, last_i)
    host.xfer(1'b1, 1'b0, 8'h3c, q);
    `CHK("data wr", 8'h3c, last_d)
    @(posedge clk_sys) core_busy <= 1'b1;
    host.xfer(1'b0, 1'b1, 8'h00, q);
    `CHK("status", 8'hda, q)
    host.xfer(1'b1, 1'b1, 8'h00, q);
    `CHK("data rd", 8'hc3, q)
    `CHK("rd ack", 1, n_ack)
    `CHK("idle", 8'hff, host_data_oe_n)
    @(posedge clk_sys) nibble_mode <= 1'b1;
    host.xfer(1'b0, 1'b0, 8'h90, q);
    host.xfer(1'b0, 1'b0, 8'h60, q);
    `CHK("nib wr", 8'h96, last_i)
    host.xfer(1'b0, 1'b1, 8'h00, q);
    `CHK("nib hi", 8'hdf, q)
    host.xfer(1'b0, 1'b1, 8'h00, q);
    `CHK("nib lo", 8'haf, q)
    @(posedge clk_sys) nibble_mode <= 1'b0;
    @(posedge clk_sys) serial_sel <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      host.put({4'h0, b[0], 3'h0});
      wt(6);
      `CHK("addr bit", b[0], serial_addr_bit)
    end
    host.xfer(1'b0, 1'b0, 8'h11, q);
    `CHK("refused", 2, n_i)
    for (int m = 0; m < 3; m++) begin
      @(posedge clk_sys) mux_rate <= m[1:0];
      wt(6);
      `CHK("bias", m == 2 ? 3'h4 : 3'h5, bias_levels)
    end
    `CHK("gen off", 1'b0, gen_enable)
    @(posedge clk_sys) vcode_a <= 6'h3f;
    wt(6);
    `CHK("code a", 7'h7f, {gen_enable, gen_code})
    @(posedge clk_sys) icon_mode <= 1'b1;
    @(posedge clk_sys) vcode_b <= 6'h01;
    wt(6);
    `CHK("code b", 7'h41, {gen_enable, gen_code})
    @(posedge clk_sys) direct_supply_bit <= 1'b1;
    wt(6);
    `CHK("direct", 2'h2, {direct_connect, gen_enable})
    @(posedge clk_sys) power_down_in <= 1'b1;
    wt(6);
    `CHK("pd", 3'h4, {power_down, direct_connect, gen_enable})
    summarize();
  end
endmodule

// file: rtl/lhp_map.vh
// What this block does
// RL1: Register select low on write loads the bus byte into instruction register.
// RL2: Register select low on read returns busy flag and address counter.
// RL3: Register select high accesses the data register for reads and writes.
// RL4: Direction input high means read, low means write.
// RL5: Data lines are tri-state, driven only during reads.
// RL6: Busy flag appears on the top data line during status reads.
// RL7: Nibble mode uses only the upper four data lines.
// RL8: In serial mode data line three sets one slave address bit.
// RL9: Host holds the strobe low while the serial interface is used.
// RL10: Power-down input high enters power-down; low is normal operation.
// RL11: Two 6-bit supply codes, programmed range 1 to 63.
// RL12: Selected supply code of zero switches the generator off.
// RL13: First code applies in character mode, second in icon mode.
// RL14: Direct mode disables generator and ties supply output to rail.
// RL15: Bias levels follow multiplex rate: five for 1:18 and 1:9, four for 1:2.
// RL16: Strobe high starts a transfer; data moves on its falling edge.
// RL17: Busy one refuses instructions; host waits for zero. This block passes instructions on whatever the busy flag.
// RL18: Internal reset completes three clock cycles after reset release.
// RL19: Nibble mode sends upper nibble first, then lower nibble.
`ifndef LHP_MAP_VH
`define LHP_MAP_VH
`define LHP_RS_INSTR      1'b0
`define LHP_RS_DATA       1'b1
`define LHP_DIR_READ      1'b1
`define LHP_DIR_WRITE     1'b0
`define LHP_BUSY_BIT      7
`define LHP_SADDR_BIT     3
`define LHP_VCODE_OFF     6'h00
`define LHP_MUX_1_18      2'h0
`define LHP_MUX_1_9       2'h1
`define LHP_MUX_1_2       2'h2
`define LHP_BIAS_5        3'h5
`define LHP_BIAS_4        3'h4
`define LHP_SYNC_RST_CYC  3
`endif

// file: rtl/lhp_port.v
`timescale 1ns/1ps
`include "lhp_map.vh"

module lhp_port #(
  parameter AC_W = 7
) (
  // Clock and reset
  input  wire            clk_sys,
  input  wire            reset_n,
  // Host pins
  input  wire            register_select,
  input  wire            read_not_write,
  input  wire            strobe,
  input  wire [7:0]      host_data_in,
  output reg  [7:0]      host_data_out,
  output reg  [7:0]      host_data_oe_n,
  // Mode and supply controls
  input  wire            nibble_mode,
  input  wire            serial_sel,
  input  wire            power_down_in,
  input  wire            icon_mode,
  input  wire            direct_supply_bit,
  input  wire [5:0]      vcode_a,
  input  wire [5:0]      vcode_b,
  input  wire [1:0]      mux_rate,
  // Core side
  input  wire            core_busy,
  input  wire [AC_W-1:0] addr_counter,
  input  wire [7:0]      read_data,
  output reg  [7:0]      instr_byte,
  output reg             instr_valid,
  output reg  [7:0]      data_byte,
  output reg             data_valid,
  output reg             data_read_ack,
  // Supply and state outputs
  output reg             gen_enable,
  output reg             direct_connect,
  output reg  [5:0]      gen_code,
  output reg  [2:0]      bias_levels,
  output reg             power_down,
  output reg             serial_addr_bit,
  output reg             sync_rst_done
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  // Host pins, power_down_in and serial_sel are asynchronous to clk_sys, so they pass two flip-flops.
  reg [12:0] sync_a;
  reg [12:0] sync_b;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync_a <= 13'h0000;
      sync_b <= 13'h0000;
    end else begin
      sync_a <= {register_select, read_not_write, strobe, host_data_in,
                 power_down_in, serial_sel};
      sync_b <= sync_a;
    end
  end
  wire       s_rs     = sync_b[12];
  wire       s_rw     = sync_b[11];
  wire       s_e      = sync_b[10];
  wire [7:0] s_db     = sync_b[9:2];
  wire       s_pd     = sync_b[1];
  wire       s_serial = sync_b[0];

  // ************************************************************
  // Internal synchronous reset
  // ************************************************************
  reg [1:0] rst_cnt;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_cnt       <= 2'h0;
      sync_rst_done <= 1'b0;
    end else if (!sync_rst_done) begin
      rst_cnt <= rst_cnt + 2'h1;
      if (rst_cnt == `LHP_SYNC_RST_CYC - 1)
        sync_rst_done <= 1'b1; // [RL18]
    end
  end

  // ************************************************************
  // Strobe edge and nibble pairing
  // ************************************************************
  reg  e_prev;
  reg  nib_second;
  reg  [3:0] nib_hi;
  reg  rd_active;
  // Strobe is ignored in serial mode; the host keeps it low there.
  wire e_fall = e_prev && !s_e && !s_serial && sync_rst_done; // [RL9] [RL16]
  wire e_rise = !e_prev && s_e && !s_serial && sync_rst_done; // [RL16]
  wire is_read = (s_rw == `LHP_DIR_READ); // [RL4]
  wire byte_done = !nibble_mode || nib_second; // [RL19]
  wire [7:0] wr_byte = nibble_mode ? {nib_hi, s_db[7:4]} : s_db; // [RL7]

  reg [7:0] rd_byte;
  always @* begin
    if (s_rs == `LHP_RS_INSTR) begin
      rd_byte = 8'h00;
      rd_byte[AC_W-1:0] = addr_counter; // [RL2]
      rd_byte[`LHP_BUSY_BIT] = core_busy; // [RL6]
    end else begin
      rd_byte = read_data; // [RL3]
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      e_prev         <= 1'b0;
      nib_second     <= 1'b0;
      nib_hi         <= 4'h0;
      rd_active      <= 1'b0;
      host_data_out  <= 8'h00;
      host_data_oe_n <= 8'hff;
      instr_byte     <= 8'h00;
      instr_valid    <= 1'b0;
      data_byte      <= 8'h00;
      data_valid     <= 1'b0;
      data_read_ack  <= 1'b0;
    end else begin
      e_prev        <= s_e;
      instr_valid   <= 1'b0;
      data_valid    <= 1'b0;
      data_read_ack <= 1'b0;
      if (e_rise && is_read) begin
        rd_active      <= 1'b1; // [RL5]
        host_data_oe_n <= nibble_mode ? 8'h0f : 8'h00; // [RL7]
        if (nibble_mode && nib_second)
          host_data_out <= {rd_byte[3:0], 4'h0}; // [RL19]
        else
          host_data_out <= rd_byte;
      end
      if (e_fall) begin
        rd_active      <= 1'b0;
        host_data_oe_n <= 8'hff; // [RL5]
        if (nibble_mode)
          nib_second <= !nib_second; // [RL19]
        if (!byte_done && !is_read)
          nib_hi <= s_db[7:4];
        if (byte_done && !is_read) begin
          // Busy refusal is left to the core; the flag only informs.
          if (s_rs == `LHP_RS_INSTR) begin
            instr_byte  <= wr_byte; // [RL1] [RL17]
            instr_valid <= 1'b1;
          end else begin
            data_byte  <= wr_byte; // [RL3]
            data_valid <= 1'b1;
          end
        end
        if (byte_done && is_read && s_rs == `LHP_RS_DATA)
          data_read_ack <= 1'b1;
      end
      if (!nibble_mode)
        nib_second <= 1'b0;
    end
  end

  // ************************************************************
  // Supply generator and bias selection
  // ************************************************************
  wire [5:0] sel_code = icon_mode ? vcode_b : vcode_a; // [RL11] [RL13]
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gen_enable      <= 1'b0;
      direct_connect  <= 1'b0;
      gen_code        <= `LHP_VCODE_OFF;
      bias_levels     <= `LHP_BIAS_5;
      power_down      <= 1'b0;
      serial_addr_bit <= 1'b0;
    end else begin
      power_down     <= s_pd; // [RL10]
      gen_code       <= sel_code;
      direct_connect <= direct_supply_bit && !s_pd; // [RL14]
      gen_enable     <= (sel_code != `LHP_VCODE_OFF) && // [RL12]
                        !direct_supply_bit && !s_pd; // [RL14]
      if (mux_rate == `LHP_MUX_1_2)
        bias_levels <= `LHP_BIAS_4; // [RL15]
      else
        bias_levels <= `LHP_BIAS_5; // [RL15]
      if (s_serial)
        serial_addr_bit <= s_db[`LHP_SADDR_BIT]; // [RL8]
    end
  end

endmodule
